// file: wake_cmp.sv
/*
  Wake-up amplitude and phase comparator: configuration, reference,
  auto-average and result registers behind an APB slave, measurement
  start on wake-up timer expiry, threshold compare and interrupt.
  Each channel keeps an 8-bit result, an 8-bit running average and a
  sticky event bit. The wake control word enables the starts on timer
  expiry; the mask word chooses which events drive IRQ. Reading the
  status word clears the bits it returned; an event in the clearing
  cycle survives. Registers sit one to a 32-bit word, data in bits
  7..0, byte address four times the index.
  Assumes TIMER_EXPIRE is a one-cycle pulse from the wake-up timer and
  that the detector answers each start with one done pulse and a value.
  Every done pulse is compared, whether or not a start was issued, so a
  detector must keep done low while idle. APB answers after one wait
  state; CE low freezes every register, the APB answer included.
*/
module wake_cmp #(
  parameter int VAL_W = 8,
  parameter int THR_W = 4,
  parameter int WGT_W = 2
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic CE,
  input wire wake_cmp_pkg::apb_req_t APB_REQ,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic TIMER_EXPIRE,
  input wire wake_cmp_pkg::meas_result_t AMP_RESULT,
  input wire wake_cmp_pkg::meas_result_t PHASE_RESULT,
  output wake_cmp_pkg::meas_start_t MEAS_START,
  output logic IRQ
);
  import wake_cmp_pkg::*;

  // the carriers and field positions fix these widths
  if (VAL_W != $bits(meas_result_t) - 1) begin : g_bad_val_w
    $error("VAL_W must match the detector result width");
  end
  if (THR_W != THR_MSB - THR_LSB + 1) begin : g_bad_thr_w
    $error("THR_W must match the threshold field");
  end
  if (WGT_W != WGT_MSB - WGT_LSB + 1) begin : g_bad_wgt_w
    $error("WGT_W must match the weight field");
  end
  if (NUM_CH != 2) begin : g_bad_num_ch
    $error("exactly two measurement channels are served");
  end
  if (ADDR_W < 9) begin : g_bad_addr_w
    $error("address must reach the status and mask words");
  end
  if (AVG_SHIFT_BASE + 3 > 8) begin : g_bad_shift
    $error("average shift must stay inside the 9-bit difference");
  end

  logic [7:0] cfg_r [NUM_CH];
  logic [7:0] ref_r [NUM_CH];
  logic [7:0] avg_r [NUM_CH];
  logic [7:0] res_r [NUM_CH];
  logic [1:0] ctrl_r;
  logic [1:0] stat_r;
  logic [1:0] stat_nxt;
  logic [1:0] stat_snap_r;
  logic [1:0] mask_r;
  logic [1:0] trig;
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;
  logic irq_r;
  meas_start_t start_r;
  meas_result_t res_in [NUM_CH];
  logic [7:0] cmp_ref [NUM_CH];
  logic [6:0] idx;
  logic aligned;
  logic access;
  logic done;
  logic wr_done;
  logic rd_clr;
  logic [7:0] rd_byte;
  logic rd_hit;
  logic first_acc;
  logic [NUM_CH-1:0] avg_take;
  logic [NUM_CH-1:0] wr_cfg;
  logic [NUM_CH-1:0] wr_ref;
  logic wr_ctrl;
  logic wr_mask;

  // distance between a result and its reference
  function automatic logic [7:0] abs_diff(input logic [7:0] a,
                                          input logic [7:0] b);
    return (a >= b) ? 8'(a - b) : 8'(b - a);
  endfunction

  // absolute difference above threshold
  function automatic logic exceeds(input logic [7:0] res,
                                   input logic [7:0] refv,
                                   input logic [3:0] thr);
    return abs_diff(res, refv) > {4'h0, thr};
  endfunction

  // configuration fields
  function automatic logic [3:0] thr_of(input logic [7:0] cfg);
    return cfg[THR_MSB:THR_LSB];
  endfunction

  function automatic logic [1:0] wgt_of(input logic [7:0] cfg);
    return cfg[WGT_MSB:WGT_LSB];
  endfunction

  function automatic logic incl_of(input logic [7:0] cfg);
    return cfg[INCL_BIT];
  endfunction

  function automatic logic sel_of(input logic [7:0] cfg);
    return cfg[SEL_BIT];
  endfunction

  // running average: avg + (res - avg) / weight
  function automatic logic [7:0] avg_step(input logic [7:0] avg,
                                          input logic [7:0] res,
                                          input logic [1:0] code);
    logic signed [8:0] delta;
    logic signed [8:0] step;
    logic [2:0] sh;
    delta = $signed({1'b0, res}) - $signed({1'b0, avg});
    sh = 3'({1'b0, code}) + AVG_SHIFT_BASE;
    step = delta >>> sh;
    return 8'(avg + step[7:0]);
  endfunction

  // register index to channel and field, used by write decode
  function automatic logic is_cfg(input logic [6:0] i, input int ch);
    return i == (ch == CH_AMP ? IDX_AMP_CFG : IDX_PHS_CFG);
  endfunction

  function automatic logic is_ref(input logic [6:0] i, input int ch);
    return i == (ch == CH_AMP ? IDX_AMP_REF : IDX_PHS_REF);
  endfunction

  assign idx = APB_REQ.paddr[ADDR_W-1:2];
  assign aligned = APB_REQ.paddr[1:0] == 2'h0;
  assign access = APB_REQ.psel & APB_REQ.penable;
  assign done = access & pready_r;
  assign first_acc = access & ~pready_r;
  assign wr_done = done & APB_REQ.pwrite & aligned & rd_hit;
  assign rd_clr = done & ~APB_REQ.pwrite & aligned & (idx == IDX_IRQ_STAT);

  assign res_in[CH_AMP] = AMP_RESULT;
  assign res_in[CH_PHS] = PHASE_RESULT;

  // reference selection and compare per channel
  always_comb begin
    for (int ch = 0; ch < NUM_CH; ch++) begin
      cmp_ref[ch] = sel_of(cfg_r[ch]) ?
        avg_r[ch] : ref_r[ch];
      trig[ch] = res_in[ch].done &
        exceeds(res_in[ch].value, cmp_ref[ch],
                thr_of(cfg_r[ch]));
      avg_take[ch] = res_in[ch].done &
        (~trig[ch] | incl_of(cfg_r[ch]));
    end
  end

  // write strobes per register
  always_comb begin
    for (int ch = 0; ch < NUM_CH; ch++) begin
      wr_cfg[ch] = wr_done & is_cfg(idx, ch);
      wr_ref[ch] = wr_done & is_ref(idx, ch);
    end
    wr_ctrl = wr_done & (idx == IDX_WAKE_CTRL);
    wr_mask = wr_done & (idx == IDX_IRQ_MASK);
  end

  // read mux
  always_comb begin
    rd_byte = 8'h00;
    rd_hit = 1'b1;
    case (idx)
      IDX_AMP_CFG: rd_byte = cfg_r[CH_AMP];
      IDX_AMP_REF: rd_byte = ref_r[CH_AMP];
      IDX_AMP_AVG: rd_byte = avg_r[CH_AMP];
      IDX_AMP_RES: rd_byte = res_r[CH_AMP];
      IDX_PHS_CFG: rd_byte = cfg_r[CH_PHS];
      IDX_PHS_REF: rd_byte = ref_r[CH_PHS];
      IDX_PHS_AVG: rd_byte = avg_r[CH_PHS];
      IDX_PHS_RES: rd_byte = res_r[CH_PHS];
      IDX_WAKE_CTRL: rd_byte = {6'h00, ctrl_r};
      IDX_IRQ_STAT: rd_byte = {6'h00, stat_r};
      IDX_IRQ_MASK: rd_byte = {6'h00, mask_r};
      default: rd_hit = 1'b0;
    endcase
  end

  // apb answer: one wait state, then PREADY for one cycle
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      pready_r <= 1'b0;
    end else if (CE) begin
      pready_r <= first_acc;
    end
  end

  // error answer on unmapped or unaligned words
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      pslverr_r <= 1'b0;
    end else if (CE) begin
      pslverr_r <= first_acc & ~(aligned & rd_hit);
    end
  end

  // read data is latched with PREADY and kept afterwards
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      prdata_r <= 32'h0000_0000;
    end else if (CE && first_acc) begin
      if (aligned && !APB_REQ.pwrite) begin
        prdata_r <= {24'h00_0000, rd_byte};
      end else begin
        prdata_r <= 32'h0000_0000;
      end
    end
  end

  // status as shown to the reader; only these bits are cleared
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      stat_snap_r <= STAT_RST;
    end else if (CE && first_acc) begin
      stat_snap_r <= stat_r;
    end
  end

  // configuration words; views and status ignore writes without error
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      for (int ch = 0; ch < NUM_CH; ch++) begin
        cfg_r[ch] <= CFG_RST;
      end
    end else if (CE) begin
      for (int ch = 0; ch < NUM_CH; ch++) begin
        if (wr_cfg[ch]) begin
          cfg_r[ch] <= APB_REQ.pwdata[7:0];
        end
      end
    end
  end

  // reference words
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      for (int ch = 0; ch < NUM_CH; ch++) begin
        ref_r[ch] <= REF_RST;
      end
    end else if (CE) begin
      for (int ch = 0; ch < NUM_CH; ch++) begin
        if (wr_ref[ch]) begin
          ref_r[ch] <= APB_REQ.pwdata[7:0];
        end
      end
    end
  end

  // wake control: start enables
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_r <= CTRL_RST;
    end else if (CE && wr_ctrl) begin
      ctrl_r <= APB_REQ.pwdata[1:0];
    end
  end

  // interrupt mask
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      mask_r <= MASK_RST;
    end else if (CE && wr_mask) begin
      mask_r <= APB_REQ.pwdata[1:0];
    end
  end

  // measurement start on timer expiry
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      start_r <= '0;
    end else if (CE) begin
      start_r.amp <= TIMER_EXPIRE & ctrl_r[CTRL_AMP_BIT];
      start_r.phase <= TIMER_EXPIRE & ctrl_r[CTRL_PHS_BIT];
    end
  end

  // latest result per channel
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      for (int ch = 0; ch < NUM_CH; ch++) begin
        res_r[ch] <= VIEW_RST;
      end
    end else if (CE) begin
      for (int ch = 0; ch < NUM_CH; ch++) begin
        if (res_in[ch].done) begin
          res_r[ch] <= res_in[ch].value;
        end
      end
    end
  end

  // auto-average; a triggering result counts only with its include bit
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      for (int ch = 0; ch < NUM_CH; ch++) begin
        avg_r[ch] <= VIEW_RST;
      end
    end else if (CE) begin
      for (int ch = 0; ch < NUM_CH; ch++) begin
        if (avg_take[ch]) begin
          avg_r[ch] <= avg_step(avg_r[ch], res_in[ch].value,
                                wgt_of(cfg_r[ch]));
        end
      end
    end
  end

  // sticky status: read clears only what was read, new events win
  always_comb begin
    stat_nxt = stat_r & ~(rd_clr ? stat_snap_r : 2'h0);
    stat_nxt[STAT_AMP_BIT] = stat_nxt[STAT_AMP_BIT] | trig[CH_AMP];
    stat_nxt[STAT_PHS_BIT] = stat_nxt[STAT_PHS_BIT] | trig[CH_PHS];
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      stat_r <= STAT_RST;
    end else if (CE) begin
      stat_r <= stat_nxt;
    end
  end

  // taken from the next status so IRQ tracks the status flops exactly
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      irq_r <= 1'b0;
    end else if (CE) begin
      irq_r <= |(stat_nxt & mask_r);
    end
  end

  assign PRDATA = prdata_r;
  assign PREADY = pready_r;
  assign PSLVERR = pslverr_r;
  assign MEAS_START = start_r;
  assign IRQ = irq_r;

endmodule // wake_cmp

// file: wake_cmp_detector.sv
/* detector model: answers each start after lat cycles
   assumes starts are one-cycle pulses */
module wake_cmp_detector (
  input wire logic clk,
  input wire wake_cmp_pkg::meas_start_t start,
  input wire logic [3:0] lat,
  input wire logic [7:0] amp_val,
  input wire logic [7:0] phs_val,
  output wake_cmp_pkg::meas_result_t amp_res,
  output wake_cmp_pkg::meas_result_t phs_res
);
  timeunit 1ns;
  timeprecision 1ns;
  import wake_cmp_pkg::*;
  initial amp_res = '0;
  initial phs_res = '0;
  // value lines carry junk outside the done cycle
  always @(posedge clk) if (start.amp) begin
    repeat (lat) @(posedge clk);
    amp_res <= '{1'b1, amp_val};
    @(posedge clk);
    amp_res <= '{1'b0, ~amp_val};
  end
  always @(posedge clk) if (start.phase) begin
    repeat (lat) @(posedge clk);
    phs_res <= '{1'b1, phs_val};
    @(posedge clk);
    phs_res <= '{1'b0, ~phs_val};
  end
endmodule // wake_cmp_detector

// file: wake_cmp_monitor.sv
/* port checker for wake_cmp
   bound to every wake_cmp instance */
module wake_cmp_monitor (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic CE,
  input wire wake_cmp_pkg::apb_req_t APB_REQ,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic TIMER_EXPIRE,
  input wire wake_cmp_pkg::meas_result_t AMP_RESULT,
  input wire wake_cmp_pkg::meas_result_t PHASE_RESULT,
  input wire wake_cmp_pkg::meas_start_t MEAS_START,
  input wire logic IRQ
);
  import wake_cmp_pkg::*;
  default clocking @(posedge CLK);
  endclocking
  default disable iff (!RST_N || !CE);
  AST_AG: assert property (MEAS_START.amp |-> $past(TIMER_EXPIRE))
    else $error("amp start w/o expiry");
  AST_PG: assert property (
    MEAS_START.phase |-> $past(TIMER_EXPIRE))
    else $error("phase start w/o expiry");
  AST_GP: assert property (
    MEAS_START != 0 && !TIMER_EXPIRE |=> MEAS_START == 0)
    else $error("start longer than a cycle");
  AST_IR: assert property ($rose(IRQ) |->
    $past(AMP_RESULT.done | PHASE_RESULT.done | PREADY) ||
    $past(AMP_RESULT.done | PHASE_RESULT.done | PREADY, 2))
    else $error("irq rose without cause");
  AST_IF: assert property ($fell(IRQ) |->
    $past(PREADY) || $past(PREADY, 2))
    else $error("irq fell without access");
  AST_ER: assert property (PSLVERR |-> PREADY && PRDATA == 0)
    else $error("error answer malformed");
  AST_RW: assert property (PREADY |->
    $past(APB_REQ.psel && APB_REQ.penable) && PRDATA[31:8] == 0)
    else $error("answer outside transfer");
  AST_RP: assert property (PREADY |=> !PREADY)
    else $error("ready longer than a cycle");
endmodule // wake_cmp_monitor
bind wake_cmp wake_cmp_monitor mon_u (.CLK, .RST_N, .CE, .APB_REQ, .PRDATA,
  .PREADY, .PSLVERR, .TIMER_EXPIRE, .AMP_RESULT, .PHASE_RESULT,
  .MEAS_START, .IRQ);

// file: wake_cmp_pkg.sv
/*
  Constants and carrier types for the wake-up amplitude and phase comparator.
  Assumes a 32-bit APB master and an analogue detector that returns one
  8-bit result per started measurement.
*/
package wake_cmp_pkg;

  localparam int NUM_CH = 2;
  localparam int CH_AMP = 0;
  localparam int CH_PHS = 1;
  localparam int ADDR_W = 9;

  // register indices; byte address is four times the index
  localparam logic [6:0] IDX_AMP_CFG = 7'h33;
  localparam logic [6:0] IDX_AMP_REF = 7'h34;
  localparam logic [6:0] IDX_AMP_AVG = 7'h35;
  localparam logic [6:0] IDX_AMP_RES = 7'h36;
  localparam logic [6:0] IDX_PHS_CFG = 7'h37;
  localparam logic [6:0] IDX_PHS_REF = 7'h38;
  localparam logic [6:0] IDX_PHS_AVG = 7'h39;
  localparam logic [6:0] IDX_PHS_RES = 7'h3A;
  localparam logic [6:0] IDX_WAKE_CTRL = 7'h40;
  localparam logic [6:0] IDX_IRQ_STAT = 7'h41;
  localparam logic [6:0] IDX_IRQ_MASK = 7'h42;

  // configuration register fields
  localparam int THR_MSB = 7;
  localparam int THR_LSB = 4;
  localparam int INCL_BIT = 3;
  localparam int WGT_MSB = 2;
  localparam int WGT_LSB = 1;
  localparam int SEL_BIT = 0;

  // weight code 0..3 selects 4, 8, 16, 32: shift of code plus this base
  localparam logic [2:0] AVG_SHIFT_BASE = 3'h2;

  // wake control, status and mask bits
  localparam int CTRL_AMP_BIT = 0;
  localparam int CTRL_PHS_BIT = 1;
  localparam int STAT_AMP_BIT = 0;
  localparam int STAT_PHS_BIT = 1;

  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [7:0] REF_RST = 8'h00;
  localparam logic [7:0] VIEW_RST = 8'h00;
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam logic [1:0] MASK_RST = 2'h0;
  localparam logic [1:0] STAT_RST = 2'h0;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic done;
    logic [7:0] value;
  } meas_result_t;

  typedef struct packed {
    logic phase;
    logic amp;
  } meas_start_t;

endpackage

// file: wake_cmp_tb_top.sv
/* self-checking bench for wake_cmp
   assumes byte address is four times the register index */
module wake_cmp_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import wake_cmp_pkg::*;
  logic clk = 0, rst_n = 0, te = 0, ce = 1, rdy, err, irq, e;
  apb_req_t req = '0;
  meas_start_t st;
  meas_result_t ares, pres;
  logic [31:0] rdata;
  logic [3:0] lat = 0;
  logic [7:0] av = 0, pv = 0, q, msk;
  int n_mismatch = 0, checks_done = 0, cyc = 0;
  wake_cmp dut_u (.CLK(clk), .RST_N(rst_n), .CE(ce), .APB_REQ(req),
    .PRDATA(rdata), .PREADY(rdy), .PSLVERR(err), .TIMER_EXPIRE(te),
    .AMP_RESULT(ares), .PHASE_RESULT(pres), .MEAS_START(st), .IRQ(irq));
  wake_cmp_detector det_u (.clk, .start(st), .lat, .amp_val(av),
    .phs_val(pv), .amp_res(ares), .phs_res(pres));
  initial forever #20 clk = ~clk;
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      end_sim;
    end
  end
  task automatic chk(input logic [7:0] s, input logic [7:0] x);
    checks_done++;
    if (s !== x) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask
  task automatic apb(input logic w, input logic [6:0] i,
      input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    req <= '{1'b1, 1'b0, w, {i, 2'b00}, {24'h0, d}};
    @(posedge clk);
    req.penable <= 1'b1;
    do @(posedge clk); while (rdy !== 1'b1 && ++n < 20);
    if (n >= 20) n_mismatch++;
    q = rdata[7:0];
    e = err;
    req <= '0;
  endtask
  task automatic pulse;
    @(posedge clk);
    te <= 1'b1;
    @(posedge clk);
    te <= 1'b0;
    @(negedge clk);
  endtask
  task automatic meas(input int ch, input logic [7:0] cfg, v, se, ae);
    int n;
    n = 0;
    apb(1, ch ? IDX_PHS_CFG : IDX_AMP_CFG, cfg);
    apb(1, IDX_WAKE_CTRL, 8'(1 << ch));
    if (ch) pv <= v;
    else av <= v;
    pulse;
    chk(8'(st), 8'(1 << ch));
    while (ares.done !== 1'b1 && pres.done !== 1'b1 && n++ < 40)
      @(negedge clk);
    chk(8'(ares.done | pres.done), 8'h01);
    @(negedge clk);
    chk(8'(irq), se & msk);
    apb(0, ch ? IDX_PHS_RES : IDX_AMP_RES, 0);
    chk(q, v);
    apb(0, IDX_IRQ_STAT, 0);
    chk(q, se);
    apb(0, ch ? IDX_PHS_AVG : IDX_AMP_AVG, 0);
    chk(q, ae);
    @(negedge clk);
    chk(8'(irq), 8'h00);
  endtask
  task automatic t_off;
    apb(1, IDX_WAKE_CTRL, 8'h03);
    ce <= 1'b0;
    pulse;
    chk(8'(st), 8'h00);
    @(posedge clk);
    ce <= 1'b1;
    apb(1, IDX_WAKE_CTRL, 8'h00);
    pulse;
    chk(8'(st), 8'h00);
    $display("test enables done");
  endtask
  task automatic t_reset;
    for (int i = 'h33; i <= 'h3A; i++) begin
      apb(0, 7'(i), 0);
      chk(q, 8'h00);
    end
    apb(0, 7'h3B, 0);
    chk(8'(e), 8'h01);
    $display("test reset done");
  endtask
  task automatic t_regs;
    apb(1, IDX_AMP_REF, 8'hA5);
    apb(1, IDX_PHS_REF, 8'h5A);
    apb(1, IDX_AMP_RES, 8'hFF);
    apb(0, IDX_AMP_REF, 0);
    chk(q, 8'hA5);
    apb(0, IDX_PHS_REF, 0);
    chk(q, 8'h5A);
    apb(0, IDX_AMP_RES, 0);
    chk(q, 8'h00);
    $display("test registers done");
  endtask
  task automatic t_amp;
    msk = 8'h03;
    apb(1, IDX_IRQ_MASK, msk);
    apb(1, IDX_AMP_REF, 8'h40);
    meas(0, 8'h30, 8'h43, 8'h00, 8'h10);
    meas(0, 8'h30, 8'h44, 8'h01, 8'h10);
    meas(0, 8'h3F, 8'h30, 8'h01, 8'h11);
    meas(0, 8'h3F, 8'h01, 8'h01, 8'h10);
    $display("test amplitude done");
  endtask
  task automatic t_phase;
    msk = 8'h01;
    lat <= 4'h7;
    apb(1, IDX_IRQ_MASK, msk);
    meas(1, 8'h82, 8'h60, 8'h00, 8'h0C);
    meas(1, 8'h81, 8'h15, 8'h02, 8'h0C);
    meas(1, 8'h0D, 8'h2C, 8'h02, 8'h0E);
    $display("test phase done");
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
    t_regs;
    t_off;
    t_amp;
    t_phase;
    end_sim;
  end
endmodule // wake_cmp_tb_top
